// ---- logic/pbchg_pkg.sv ----
// Package for the second port with change interrupt.
// Assumes a 32-bit Avalon-MM register slave with word addressing by byte offset.
package pbchg_pkg;
    localparam int DATA_W = 32;
    localparam int ADDR_W = 6;
    localparam int PORT_W = 8;
    // Register byte offsets
    localparam logic [ADDR_W-1:0] OFF_PINS = 6'h00;
    localparam logic [ADDR_W-1:0] OFF_DIR = 6'h04;
    localparam logic [ADDR_W-1:0] OFF_LATCH = 6'h08;
    localparam logic [ADDR_W-1:0] OFF_INTMAIN = 6'h0c;
    localparam logic [ADDR_W-1:0] OFF_INTSECOND = 6'h10;
    localparam logic [ADDR_W-1:0] OFF_CFG = 6'h14;
    localparam logic [ADDR_W-1:0] OFF_IRQSTAT = 6'h18;
    localparam logic [ADDR_W-1:0] OFF_IRQMASK = 6'h1c;
    localparam logic [ADDR_W-1:0] OFF_PINSNOREF = 6'h20;
    // Field positions
    localparam int INTMAIN_FLAG_BIT = 0;
    localparam int INTMAIN_ENABLE_BIT = 3;
    localparam int INTSECOND_PRIO_BIT = 0;
    localparam int INTSECOND_PULLUPN_BIT = 7;
    localparam int CFG_SLEEP_BIT = 0;
    localparam int CFG_ANALOG_BIT = 1;
    localparam int CHG_LO = 4;
    localparam int ANALOG_HI = 4;
    localparam int STAT_CHANGE_BIT = 0;
    localparam int STAT_WAKE_BIT = 1;
    localparam int STAT_W = 2;
    // Reset values
    localparam logic [PORT_W-1:0] DIR_RST = 8'hff;
    localparam logic [PORT_W-1:0] LATCH_RST = 8'h00;
    localparam logic [7:0] INTSECOND_RST = 8'h81;
    localparam logic [STAT_W-1:0] MASK_RST = 2'h0;
    localparam logic [DATA_W-1:0] UNMAPPED_VAL = 32'h0000_0000;
    localparam int SYNC_STAGES = 2;
endpackage

// ---- logic/pbchg_sync.sv ----
// Two-flop synchroniser for the port pin inputs.
// Assumes pins are asynchronous to sys_clk.
`timescale 1ns/1ps
module pbchg_sync (
    input wire logic sys_clk,
    input wire logic rstn,
    input wire logic [pbchg_pkg::PORT_W-1:0] asyncIn,
    output logic [pbchg_pkg::PORT_W-1:0] syncOut
);
    import pbchg_pkg::*;
    logic [PORT_W-1:0] meta_ff;
    always_ff @(posedge sys_clk or negedge rstn) begin
        if (!rstn) begin
            meta_ff <= '0;
            syncOut <= '0;
        end else begin
            meta_ff <= asyncIn;
            syncOut <= meta_ff;
        end
    end
endmodule

// ---- logic/pbchg_irq.sv ----
// Sticky interrupt status with mask; read of status clears it.
// Assumes events and read strobe come from sys_clk logic.
`timescale 1ns/1ps
module pbchg_irq (
    input wire logic sys_clk,
    input wire logic rstn,
    input wire logic [pbchg_pkg::STAT_W-1:0] events,
    input wire logic statRead,
    input wire logic maskWrite,
    input wire logic [pbchg_pkg::STAT_W-1:0] maskData,
    output logic [pbchg_pkg::STAT_W-1:0] status_ff,
    output logic [pbchg_pkg::STAT_W-1:0] mask_ff,
    output logic irq_ff
);
    import pbchg_pkg::*;
    // Set wins over the read clear
    always_ff @(posedge sys_clk or negedge rstn) begin
        if (!rstn) begin
            status_ff <= '0;
        end else begin
            status_ff <= (statRead ? '0 : status_ff) | events;
        end
    end
    always_ff @(posedge sys_clk or negedge rstn) begin
        if (!rstn) begin
            mask_ff <= MASK_RST;
        end else if (maskWrite) begin
            mask_ff <= maskData;
        end
    end
    always_ff @(posedge sys_clk or negedge rstn) begin
        if (!rstn) begin
            irq_ff <= 1'b0;
        end else begin
            irq_ff <= |(((statRead ? '0 : status_ff) | events) & mask_ff);
        end
    end
endmodule

// ---- logic/pbchg_port.sv ----
// Second port: 8-bit bidirectional pins, latch, pull-ups, change interrupt.
// Assumes Avalon-MM master on sys_clk; pins are asynchronous.
`timescale 1ns/1ps
// Behaviour
// - Eight pins, each with its own direction bit.
// - Direction bit 1 tristates the pin driver.
// - Direction bit 0 drives the latch bit onto the pin.
// - Latch register reads back latched value, not pin levels.
// - Clearing pull-up control bit 7 enables all weak pull-ups.
// - Pull-up is off on any pin set as output.
// - Any reset leaves pull-ups disabled.
// - Analog-default config bit makes pins 4..0 digital at reset.
// - Only input pins 7..4 join change detection.
// - Pins compare against value captured at the last port read or write.
// - Mismatches of pins 7..4 ORed set flag bit 0.
// - Port change can wake the device from sleep.
// - Port read or write ends mismatch, except file-to-file move writes.
// - Persistent mismatch keeps setting the flag despite clears.
// - Enable bit 3 gates the port change interrupt; irq status bit 0 still sets on a change while it is clear.
// - Priority bit 0 of second control steers the interrupt.
module pbchg_port (
    input wire logic sys_clk,
    input wire logic rstn,
    input wire logic [pbchg_pkg::ADDR_W-1:0] avs_address,
    input wire logic avs_read,
    input wire logic avs_write,
    input wire logic [pbchg_pkg::DATA_W-1:0] avs_writedata,
    input wire logic [3:0] avs_byteenable,
    output logic [pbchg_pkg::DATA_W-1:0] avs_readdata,
    output logic avs_waitrequest,
    input wire logic [pbchg_pkg::PORT_W-1:0] second_port_pins_in,
    output logic [pbchg_pkg::PORT_W-1:0] second_port_pins_out,
    output logic [pbchg_pkg::PORT_W-1:0] second_port_pins_oe,
    output logic [pbchg_pkg::PORT_W-1:0] pullup_on,
    input wire logic analog_default_select,
    output logic change_int_high,
    output logic change_int_low,
    output logic wake_request,
    output logic irq
);
    import pbchg_pkg::*;

    logic [PORT_W-1:0] pinSync;
    logic [PORT_W-1:0] pin_direction_reg_ff;
    logic [PORT_W-1:0] output_latch_reg_ff;
    logic [PORT_W-1:0] analog_ff;
    logic [PORT_W-1:0] changeRef_ff;
    logic [7:0] int_control_second_ff;
    logic change_int_flag_ff;
    logic change_int_enable_ff;
    logic sleep_ff;
    logic strapDone_ff;
    logic ack_ff;
    logic [DATA_W-1:0] avs_readdata_ff;
    logic [PORT_W-1:0] second_port_pins_out_ff;
    logic [PORT_W-1:0] second_port_pins_oe_ff;
    logic [PORT_W-1:0] pullup_on_ff;
    logic change_int_high_ff;
    logic change_int_low_ff;
    logic wake_request_ff;
    logic [STAT_W-1:0] status;
    logic [STAT_W-1:0] mask;
    logic irqFf;

    function automatic logic hit(input logic [ADDR_W-1:0] a, input logic [ADDR_W-1:0] off);
        return a == off;
    endfunction

    pbchg_sync u_sync (
        .sys_clk(sys_clk),
        .rstn(rstn),
        .asyncIn(second_port_pins_in),
        .syncOut(pinSync)
    );

    // One-cycle wait then acknowledge
    logic req;
    logic rdStb;
    logic wrStb;
    assign req = avs_read | avs_write;
    logic waitReq_ff;
    // Read data and status clear share one edge, so no event slips between
    assign rdStb = avs_read & ~ack_ff;
    assign wrStb = avs_write & ack_ff & avs_byteenable[0];
    always_ff @(posedge sys_clk or negedge rstn) begin
        if (!rstn) begin
            ack_ff <= 1'b0;
            waitReq_ff <= 1'b1;
        end else begin
            ack_ff <= req & ~ack_ff;
            waitReq_ff <= ~(req & ~ack_ff);
        end
    end
    assign avs_waitrequest = waitReq_ff;

    // Digital pin levels; analog pins read zero
    logic [PORT_W-1:0] pinLevel;
    assign pinLevel = pinSync & ~analog_ff;

    logic [DATA_W-1:0] nxt_readdata;
    always_comb begin
        nxt_readdata = UNMAPPED_VAL;
        case (avs_address)
            OFF_PINS: nxt_readdata = {24'h000000, pinLevel};
            OFF_PINSNOREF: nxt_readdata = {24'h000000, pinLevel};
            OFF_DIR: nxt_readdata = {24'h000000, pin_direction_reg_ff};
            OFF_LATCH: nxt_readdata = {24'h000000, output_latch_reg_ff};
            OFF_INTMAIN: begin
                nxt_readdata[INTMAIN_FLAG_BIT] = change_int_flag_ff;
                nxt_readdata[INTMAIN_ENABLE_BIT] = change_int_enable_ff;
            end
            OFF_INTSECOND: nxt_readdata = {24'h000000, int_control_second_ff};
            OFF_CFG: begin
                nxt_readdata[CFG_SLEEP_BIT] = sleep_ff;
                nxt_readdata[CFG_ANALOG_BIT] = analog_default_select;
            end
            OFF_IRQSTAT: nxt_readdata = {{(DATA_W-STAT_W){1'b0}}, status};
            OFF_IRQMASK: nxt_readdata = {{(DATA_W-STAT_W){1'b0}}, mask};
            default: nxt_readdata = UNMAPPED_VAL;
        endcase
    end
    always_ff @(posedge sys_clk or negedge rstn) begin
        if (!rstn) begin
            avs_readdata_ff <= UNMAPPED_VAL;
        end else if (rdStb) begin
            avs_readdata_ff <= nxt_readdata;
        end
    end
    assign avs_readdata = avs_readdata_ff;

    always_ff @(posedge sys_clk or negedge rstn) begin
        if (!rstn) begin
            pin_direction_reg_ff <= DIR_RST;
        end else if (wrStb && hit(avs_address, OFF_DIR)) begin
            pin_direction_reg_ff <= avs_writedata[PORT_W-1:0];
        end
    end

    // Port writes land in the latch too
    always_ff @(posedge sys_clk or negedge rstn) begin
        if (!rstn) begin
            output_latch_reg_ff <= LATCH_RST;
        end else if (wrStb && (hit(avs_address, OFF_LATCH) || hit(avs_address, OFF_PINS)
                || hit(avs_address, OFF_PINSNOREF))) begin
            output_latch_reg_ff <= avs_writedata[PORT_W-1:0];
        end
    end

    always_ff @(posedge sys_clk or negedge rstn) begin
        if (!rstn) begin
            int_control_second_ff <= INTSECOND_RST;
        end else if (wrStb && hit(avs_address, OFF_INTSECOND)) begin
            int_control_second_ff <= avs_writedata[7:0];
        end
    end

    // Sleep is software owned; wake request holds until software clears it
    always_ff @(posedge sys_clk or negedge rstn) begin
        if (!rstn) begin
            sleep_ff <= 1'b0;
        end else if (wrStb && hit(avs_address, OFF_CFG)) begin
            sleep_ff <= avs_writedata[CFG_SLEEP_BIT];
        end
    end

    // Analog state caught one cycle after reset release
    always_ff @(posedge sys_clk or negedge rstn) begin
        if (!rstn) begin
            strapDone_ff <= 1'b0;
            analog_ff <= {{(PORT_W-ANALOG_HI-1){1'b0}}, {(ANALOG_HI+1){1'b1}}};
        end else if (!strapDone_ff) begin
            strapDone_ff <= 1'b1;
            analog_ff <= analog_default_select ? '0 : analog_ff;
        end
    end

    // Change reference, captured by any port access except the move-write alias
    logic portAccess;
    assign portAccess = ack_ff && (avs_read || avs_write)
        && (hit(avs_address, OFF_PINS) || (avs_read && hit(avs_address, OFF_PINSNOREF)));
    always_ff @(posedge sys_clk or negedge rstn) begin
        if (!rstn) begin
            changeRef_ff <= '0;
        end else if (portAccess) begin
            changeRef_ff <= pinLevel;
        end
    end

    logic [PORT_W-1:0] mismatch;
    logic changeEvent;
    assign mismatch = (pinLevel ^ changeRef_ff) & pin_direction_reg_ff;
    assign changeEvent = |mismatch[PORT_W-1:CHG_LO] && !portAccess;

    // Set wins over a software clear while mismatch holds
    always_ff @(posedge sys_clk or negedge rstn) begin
        if (!rstn) begin
            change_int_flag_ff <= 1'b0;
            change_int_enable_ff <= 1'b0;
        end else begin
            if (wrStb && hit(avs_address, OFF_INTMAIN)) begin
                change_int_enable_ff <= avs_writedata[INTMAIN_ENABLE_BIT];
                change_int_flag_ff <= avs_writedata[INTMAIN_FLAG_BIT] | changeEvent;
            end else if (changeEvent) begin
                change_int_flag_ff <= 1'b1;
            end
        end
    end

    // Pin drive and pull-ups
    always_ff @(posedge sys_clk or negedge rstn) begin
        if (!rstn) begin
            second_port_pins_out_ff <= '0;
            second_port_pins_oe_ff <= '0;
            pullup_on_ff <= '0;
        end else begin
            second_port_pins_out_ff <= output_latch_reg_ff;
            second_port_pins_oe_ff <= ~pin_direction_reg_ff;
            pullup_on_ff <= {PORT_W{~int_control_second_ff[INTSECOND_PULLUPN_BIT]}}
                & pin_direction_reg_ff;
        end
    end

    // Interrupt request by priority
    always_ff @(posedge sys_clk or negedge rstn) begin
        if (!rstn) begin
            change_int_high_ff <= 1'b0;
            change_int_low_ff <= 1'b0;
            wake_request_ff <= 1'b0;
        end else begin
            change_int_high_ff <= change_int_flag_ff & change_int_enable_ff
                & int_control_second_ff[INTSECOND_PRIO_BIT];
            change_int_low_ff <= change_int_flag_ff & change_int_enable_ff
                & ~int_control_second_ff[INTSECOND_PRIO_BIT];
            wake_request_ff <= sleep_ff & change_int_flag_ff & change_int_enable_ff;
        end
    end

    logic [STAT_W-1:0] irqEvents;
    assign irqEvents = {wake_request_ff, changeEvent & ~change_int_flag_ff};

    pbchg_irq u_irq (
        .sys_clk(sys_clk),
        .rstn(rstn),
        .events(irqEvents),
        .statRead(rdStb && hit(avs_address, OFF_IRQSTAT)),
        .maskWrite(wrStb && hit(avs_address, OFF_IRQMASK)),
        .maskData(avs_writedata[STAT_W-1:0]),
        .status_ff(status),
        .mask_ff(mask),
        .irq_ff(irqFf)
    );

    assign second_port_pins_out = second_port_pins_out_ff;
    assign second_port_pins_oe = second_port_pins_oe_ff;
    assign pullup_on = pullup_on_ff;
    assign change_int_high = change_int_high_ff;
    assign change_int_low = change_int_low_ff;
    assign wake_request = wake_request_ff;
    assign irq = irqFf;

    property p_oe_follows_dir;
        @(posedge sys_clk) disable iff (!rstn)
        1'b1 |=> second_port_pins_oe == ~$past(pin_direction_reg_ff);
    endproperty
    a_oe_follows_dir: assert property (p_oe_follows_dir)
        else $error("Output enable does not follow direction");

    property p_out_follows_latch;
        @(posedge sys_clk) disable iff (!rstn)
        1'b1 |=> second_port_pins_out == $past(output_latch_reg_ff);
    endproperty
    a_out_follows_latch: assert property (p_out_follows_latch)
        else $error("Pin output does not follow latch");

    property p_pullup_off_output;
        @(posedge sys_clk) disable iff (!rstn)
        1'b1 |=> (pullup_on & ~$past(pin_direction_reg_ff)) == '0;
    endproperty
    a_pullup_off_output: assert property (p_pullup_off_output)
        else $error("Pull-up on an output pin");

    property p_pullup_ctrl;
        @(posedge sys_clk) disable iff (!rstn)
        $past(int_control_second_ff[INTSECOND_PULLUPN_BIT]) |-> pullup_on == '0;
    endproperty
    a_pullup_ctrl: assert property (p_pullup_ctrl)
        else $error("Pull-up on while control set");

    property p_flag_sets;
        @(posedge sys_clk) disable iff (!rstn)
        changeEvent |=> change_int_flag_ff;
    endproperty
    a_flag_sets: assert property (p_flag_sets)
        else $error("Mismatch did not set flag");

    property p_low_excluded;
        @(posedge sys_clk) disable iff (!rstn)
        (mismatch[PORT_W-1:CHG_LO] == '0) |-> !changeEvent;
    endproperty
    a_low_excluded: assert property (p_low_excluded)
        else $error("Change event without upper mismatch");

    property p_ref_capture;
        @(posedge sys_clk) disable iff (!rstn)
        portAccess |=> changeRef_ff == $past(pinLevel);
    endproperty
    a_ref_capture: assert property (p_ref_capture)
        else $error("Reference not captured on port access");

    property p_high_prio;
        @(posedge sys_clk) disable iff (!rstn)
        change_int_high |-> !change_int_low;
    endproperty
    a_high_prio: assert property (p_high_prio)
        else $error("Both priorities asserted");

    property p_enable_gate;
        @(posedge sys_clk) disable iff (!rstn)
        !$past(change_int_enable_ff) |-> !change_int_high && !change_int_low;
    endproperty
    a_enable_gate: assert property (p_enable_gate)
        else $error("Interrupt while disabled");

    property p_wake_needs_sleep;
        @(posedge sys_clk) disable iff (!rstn)
        wake_request |-> $past(sleep_ff) && $past(change_int_enable_ff);
    endproperty
    a_wake_needs_sleep: assert property (p_wake_needs_sleep)
        else $error("Wake request without sleep and enable");

    property p_analog_reads_zero;
        @(posedge sys_clk) disable iff (!rstn)
        rdStb && hit(avs_address, OFF_PINS) |=> (avs_readdata[PORT_W-1:0] & $past(analog_ff)) == '0;
    endproperty
    a_analog_reads_zero: assert property (p_analog_reads_zero)
        else $error("Analog pin read as nonzero");

    property p_one_wait;
        @(posedge sys_clk) disable iff (!rstn)
        req && avs_waitrequest |=> !avs_waitrequest;
    endproperty
    a_one_wait: assert property (p_one_wait)
        else $error("Request not answered after one wait cycle");

    property p_refused_write;
        @(posedge sys_clk) disable iff (!rstn)
        avs_write && !avs_byteenable[0] |=> $stable(output_latch_reg_ff) && $stable(pin_direction_reg_ff);
    endproperty
    a_refused_write: assert property (p_refused_write)
        else $error("Write without low byte enable took effect");
endmodule

// ---- verification/pbchg_pins_model.sv ----
// Pin-side model: keys, weak pull-ups and floating lines of the second port.
// Assumes the design's pin outputs, enables and pull-up controls are fed in.
`timescale 1ns/1ps
module pbchg_pins_model (
    input wire logic sys_clk,
    input wire logic [7:0] pinOut,
    input wire logic [7:0] pinOe,
    input wire logic [7:0] pullOn,
    input wire logic [7:0] keyDrive,
    input wire logic [7:0] keyVal,
    output logic [7:0] pinLevel
);
    logic [7:0] floatPat = 8'h55;
    // Undriven lines wander every cycle
    always @(posedge sys_clk) floatPat <= ~floatPat;
    always_comb begin
        for (int i = 0; i < 8; i++) begin
            if (pinOe[i]) pinLevel[i] = pinOut[i];
            else if (keyDrive[i]) pinLevel[i] = keyVal[i];
            else if (pullOn[i]) pinLevel[i] = 1'b1;
            else pinLevel[i] = floatPat[i];
        end
    end
endmodule

// ---- verification/test_pbchg_port.sv ----
// Testbench for the second port: Avalon-MM tasks, pin keys, queued read checks.
// Assumes pbchg_port with the pin model on its pins and a 40 MHz clock.
`timescale 1ns/1ps
module test_pbchg_port;
    import pbchg_pkg::*;
    logic sys_clk = 1'b0;
    logic rstn = 1'b0;
    logic [ADDR_W-1:0] avs_address = '0;
    logic avs_read = 1'b0;
    logic avs_write = 1'b0;
    logic [DATA_W-1:0] avs_writedata = '0;
    logic [3:0] avs_byteenable = 4'hf;
    logic [DATA_W-1:0] avs_readdata;
    logic avs_waitrequest;
    logic [PORT_W-1:0] pinIn, pinOut, pinOe, pullOn;
    logic [7:0] keyDrive = 8'hff;
    logic [7:0] keyVal = 8'h00;
    logic strap = 1'b0;
    logic chgHigh, chgLow, wakeReq, irq;
    int fails = 0;
    int checks = 0;
    int cyc = 0;
    logic [DATA_W-1:0] expQ[$];
    logic [DATA_W-1:0] mskQ[$];
    logic [DATA_W-1:0] e, m;
    logic [7:0] d, l, k, l2;

    initial begin
        forever #12.5 sys_clk = ~sys_clk;
    end

    pbchg_port i_dut (.sys_clk(sys_clk), .rstn(rstn), .avs_address(avs_address), .avs_read(avs_read),
        .avs_write(avs_write), .avs_writedata(avs_writedata), .avs_byteenable(avs_byteenable),
        .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest), .second_port_pins_in(pinIn),
        .second_port_pins_out(pinOut), .second_port_pins_oe(pinOe), .pullup_on(pullOn),
        .analog_default_select(strap), .change_int_high(chgHigh), .change_int_low(chgLow),
        .wake_request(wakeReq), .irq(irq));
    pbchg_pins_model i_pins (.sys_clk(sys_clk), .pinOut(pinOut), .pinOe(pinOe), .pullOn(pullOn),
        .keyDrive(keyDrive), .keyVal(keyVal), .pinLevel(pinIn));

    task automatic final_report;
        if (expQ.size() != 0) begin
            fails++;
        end
        if (fails == 0 && checks > 0) begin
            $display("Test passed");
        end else begin
            $display("Test failed");
        end
        $finish;
    endtask

    task automatic chk(input logic [DATA_W-1:0] got, input logic [DATA_W-1:0] exp);
        checks++;
        if (got !== exp) begin
            fails++;
            $display("[FAIL] %0t output %h expected %h", $time, got, exp);
        end
    endtask

    // Read results are matched against the oldest queued note
    always @(posedge sys_clk) begin
        if (avs_read && avs_waitrequest === 1'b0) begin
            e = expQ.pop_front();
            m = mskQ.pop_front();
            checks++;
            if ((avs_readdata & m) !== (e & m)) begin
                fails++;
                $display("[FAIL] %0t read %h expected %h", $time, avs_readdata, e);
            end
        end
    end

    always @(posedge sys_clk) begin
        cyc++;
        if (cyc == 20000) begin
            fails++;
            final_report();
        end
    end

    task automatic bus(input logic isWr, input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] wd,
        input logic [3:0] be);
        @(posedge sys_clk);
        avs_address <= a;
        avs_writedata <= wd;
        avs_byteenable <= be;
        avs_read <= ~isWr;
        avs_write <= isWr;
        do begin
            @(posedge sys_clk);
        end while (avs_waitrequest !== 1'b0);
        avs_read <= 1'b0;
        avs_write <= 1'b0;
    endtask

    task automatic wr(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] wd);
        bus(1'b1, a, wd, 4'hf);
    endtask

    task automatic rd(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] ex, input logic [DATA_W-1:0] mk);
        expQ.push_back(ex);
        mskQ.push_back(mk);
        bus(1'b0, a, '0, 4'hf);
    endtask

    task automatic tick(input int n);
        repeat (n) @(posedge sys_clk);
    endtask

    task automatic do_reset(input logic s);
        strap <= s;
        rstn <= 1'b0;
        tick(4);
        rstn <= 1'b1;
        tick(2);
    endtask

    initial begin
        void'($urandom(54));
        // Reset values, analog low pins
        do_reset(1'b0);
        keyVal <= 8'hff;
        tick(6);
        chk(pullOn, 8'h00);
        chk(pinOe, 8'h00);
        rd(OFF_DIR, 32'hff, '1);
        rd(OFF_LATCH, 32'h00, '1);
        rd(OFF_INTSECOND, 32'h81, '1);
        rd(OFF_PINS, 32'he0, '1);
        rd(OFF_CFG, 32'h0, 32'h2);
        // Direction, latch and pin reads
        do_reset(1'b1);
        d = 8'($urandom);
        l = 8'($urandom);
        k = 8'($urandom);
        keyVal <= k;
        wr(OFF_DIR, {24'h0, d});
        wr(OFF_LATCH, {24'h0, l});
        tick(6);
        chk(pinOe, 8'(~d));
        chk(pinOut, l);
        rd(OFF_LATCH, {24'h0, l}, '1);
        rd(OFF_PINS, {24'h0, (l & ~d) | (k & d)}, '1);
        l2 = 8'($urandom);
        wr(OFF_PINS, {24'h0, l2});
        bus(1'b1, OFF_LATCH, ~32'h0, 4'he);
        rd(OFF_LATCH, {24'h0, l2}, '1);
        rd(6'h3c, 32'h0, '1);
        // Pull-ups only on input pins
        keyDrive <= 8'h00;
        wr(OFF_DIR, 32'h0f);
        wr(OFF_LATCH, 32'h00);
        wr(OFF_INTSECOND, 32'h01);
        tick(6);
        chk(pullOn, 8'h0f);
        rd(OFF_PINS, 32'h0f, '1);
        do_reset(1'b1);
        chk(pullOn, 8'h00);
        rd(OFF_INTSECOND, 32'h81, '1);
        rd(OFF_CFG, 32'h2, 32'h2);
        // Change detection on pins 7..4
        keyDrive <= 8'hff;
        keyVal <= 8'h00;
        tick(6);
        rd(OFF_PINS, 32'h0, '1);
        wr(OFF_INTMAIN, 32'h0);
        rd(OFF_IRQSTAT, 32'h0, 32'h0);
        keyVal <= 8'h04;
        tick(6);
        rd(OFF_INTMAIN, 32'h0, 32'h1);
        wr(OFF_DIR, 32'hdf);
        wr(OFF_LATCH, 32'h20);
        tick(6);
        rd(OFF_INTMAIN, 32'h0, 32'h1);
        keyVal <= 8'h44;
        tick(6);
        rd(OFF_INTMAIN, 32'h1, 32'h1);
        chk(chgHigh, 1'b0);
        wr(OFF_INTMAIN, 32'h08);
        rd(OFF_INTMAIN, 32'h9, 32'hff);
        tick(2);
        chk({chgHigh, chgLow}, 2'b10);
        wr(OFF_INTSECOND, 32'h80);
        tick(2);
        chk({chgHigh, chgLow}, 2'b01);
        wr(OFF_PINSNOREF, 32'h20);
        wr(OFF_INTMAIN, 32'h08);
        rd(OFF_INTMAIN, 32'h9, 32'hff);
        wr(OFF_PINS, 32'h20);
        wr(OFF_INTMAIN, 32'h08);
        rd(OFF_INTMAIN, 32'h8, 32'hff);
        tick(2);
        chk({chgHigh, chgLow}, 2'b00);
        // Sticky status, mask and wake
        chk(irq, 1'b0);
        rd(OFF_IRQSTAT, 32'h1, 32'h3);
        wr(OFF_IRQMASK, 32'h3);
        wr(OFF_CFG, 32'h1);
        keyVal <= 8'hc4;
        tick(6);
        chk(wakeReq, 1'b1);
        chk(irq, 1'b1);
        rd(OFF_IRQMASK, 32'h3, '1);
        wr(OFF_PINS, 32'h20);
        rd(OFF_PINSNOREF, 32'he4, '1);
        wr(OFF_CFG, 32'h0);
        rd(OFF_IRQSTAT, 32'h3, 32'h3);
        tick(3);
        chk(irq, 1'b0);
        final_report();
    end
endmodule
